// ### verilog/mis_pkg.sv
// Constants and carrier types for the management interrupt sequencer.
//
// Contract
// - After the current operation completes, the block drives the request pin low.
// - After the last restore read, drive the pin high two cycles, then release.
// - The management request is never masked, in any operating mode.
// - In management mode, grant bus hold, float the strobe, keep driving request.
// - Save transfers come first and use the management strobe and ready pair.
// - Each saved word goes to its own fixed 24-bit address in two ranges.
// - Save and restore each take exactly 114 transfer cycles.
// - After save, enter real mode with reset values, fetching at FFFFF0h.
// - Entering management mode disables maskable and non-maskable interrupts.
// - Port I/O in management mode uses the normal strobe and ready.
// - Restore opcode reloads registers from base segment times 16 plus offset.
// - After restore, release the request pin and resume in the previous mode.
// - With debug bit 12 set, opcode F1h raises the request from inside.
// - Cross-space moves use normal strobe and ready; misaligned operands split.
// - With I/O break enabled, stall after port I/O until ready goes low.
// - After a break releases, take a pending interrupt at once, else continue.
// - The break never applies to memory-mapped I/O or coprocessor cycles.
// - Prefetches before the first management strobe are never executed.
package mis_pkg;

  localparam int unsigned MIS_XFER_COUNT    = 114;
  localparam int unsigned MIS_RANGE_A_WORDS = 102;
  localparam logic [23:0] MIS_RANGE_A_BASE  = 24'h06_0000;
  localparam logic [23:0] MIS_RANGE_B_BASE  = 24'h06_0100;
  localparam logic [23:0] MIS_RANGE_A_END   = 24'h06_00CB;
  localparam logic [23:0] MIS_RANGE_B_END   = 24'h06_0127;
  localparam logic [23:0] MIS_RANGE_B_REL   = MIS_RANGE_B_BASE - MIS_RANGE_A_BASE;
  localparam logic [23:0] MIS_WORD_STEP     = 24'h00_0002;
  localparam logic [23:0] MIS_HANDLER_FETCH = 24'hFF_FFF0;
  localparam int unsigned MIS_DBG_SOFT_BIT  = 12;
  localparam logic [1:0]  MIS_RELEASE_HIGH  = 2'h2;
  localparam logic [6:0]  MIS_XFER_LAST     = 7'h71;
  localparam logic [6:0]  MIS_RANGE_A_LAST  = 7'h65;

  typedef enum logic [3:0] {
    MIS_IDLE,
    MIS_WAIT_DONE,
    MIS_SAVE_REQ,
    MIS_SAVE_WAIT,
    MIS_HANDLER,
    MIS_REST_REQ,
    MIS_REST_WAIT,
    MIS_RELEASE
  } mis_state_e;

  // Requests from the processor core, all on the core clock.
  typedef struct packed {
    logic        op_done;
    logic        soft_trap;
    logic [31:0] debug_control_reg;
    logic        restore_op;
    logic [15:0] seg_base;
    logic [31:0] offset_reg;
    logic        io_done;
    logic        io_is_port;
    logic        cycle_is_io;
    logic        cycle_is_xmove;
    logic [15:0] save_word;
  } mis_core_req_s;

  // Indications back to the core.
  typedef struct packed {
    logic        mgmt_mode;
    logic        irq_disable;
    logic        enter_handler;
    logic [23:0] handler_fetch;
    logic        resume;
    logic        discard_prefetch;
    logic        exec_stall;
    logic        use_mgmt_space;
    logic        restore_valid;
    logic [15:0] restore_word;
  } mis_core_rsp_s;

endpackage

// ### verilog/mis_sequencer.sv
// Management interrupt sequencer: recognition, state save and restore, I/O break.
`timescale 1ns/10ps
module mis_sequencer
  import mis_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  input  wire logic          mgmt_irq_n_in,
  output logic               mgmt_irq_n_out,
  output logic               mgmt_irq_n_oe,
  output logic               mgmt_space_addr_strobe_n,
  output logic               mgmt_space_strobe_oe,
  output logic [23:0]        mgmt_space_addr,
  output logic [15:0]        mgmt_space_wdata,
  output logic               mgmt_space_write,
  input  wire logic [15:0]   mgmt_space_rdata,
  input  wire logic          mgmt_space_ready_n,
  input  wire logic          hold_req,
  output logic               hold_ack,
  input  wire logic          io_break_enable_n,
  input  wire logic          ready_n,
  input  wire mis_core_req_s core_req,
  output mis_core_rsp_s      core_rsp
);

  mis_state_e  state_ff;
  mis_state_e  nxt_state;
  logic [1:0]  irq_sync_ff;
  logic [1:0]  rdy_sync_ff;
  logic [1:0]  hold_sync_ff;
  logic [1:0]  brk_sync_ff;
  logic [1:0]  nrdy_sync_ff;
  logic [6:0]  xfer_idx_ff;
  logic [1:0]  high_cnt_ff;
  logic [23:0] rest_base_ff;
  logic        irq_oe_ff;
  logic        irq_out_ff;
  logic        strobe_n_ff;
  logic        strobe_oe_ff;
  logic [23:0] addr_ff;
  logic [15:0] wdata_ff;
  logic        write_ff;
  logic        hold_ack_ff;
  logic        pend_ff;
  mis_core_rsp_s rsp_ff;
  logic        irq_low;
  logic        space_rdy;
  logic        hold_in;
  logic        brk_en;
  logic        io_rdy;
  logic        soft_req;
  logic        in_mgmt;
  logic        hold_gap;
  logic [23:0] rel_addr;
  logic        nxt_stall;

  // Two-flop synchronisers for every pin input except the read data; only the second stage is read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_sync_ff  <= 2'h3;
      rdy_sync_ff  <= 2'h3;
      hold_sync_ff <= 2'h0;
      brk_sync_ff  <= 2'h3;
      nrdy_sync_ff <= 2'h3;
    end else if (clk_en) begin
      irq_sync_ff  <= {irq_sync_ff[0], mgmt_irq_n_in};
      rdy_sync_ff  <= {rdy_sync_ff[0], mgmt_space_ready_n};
      hold_sync_ff <= {hold_sync_ff[0], hold_req};
      brk_sync_ff  <= {brk_sync_ff[0], io_break_enable_n};
      nrdy_sync_ff <= {nrdy_sync_ff[0], ready_n};
    end
  end

  // Decoded conditions from synchronised pins and core requests.
  assign irq_low   = !irq_sync_ff[1];
  assign space_rdy = !rdy_sync_ff[1];
  assign hold_in   = hold_sync_ff[1];
  assign brk_en    = !brk_sync_ff[1];
  assign io_rdy    = !nrdy_sync_ff[1];
  assign soft_req  = core_req.soft_trap && core_req.debug_control_reg[MIS_DBG_SOFT_BIT];
  assign in_mgmt   = (state_ff != MIS_IDLE) && (state_ff != MIS_WAIT_DONE);
  assign hold_gap  = hold_ack_ff || (hold_in && in_mgmt && (state_ff != MIS_SAVE_WAIT)
                     && (state_ff != MIS_REST_WAIT));
  // Word offset within the save area: range A first, the remainder in range B.
  assign rel_addr  = (xfer_idx_ff <= MIS_RANGE_A_LAST) ?
                     24'({xfer_idx_ff, 1'b0}) :
                     MIS_RANGE_B_REL + 24'({xfer_idx_ff - (MIS_RANGE_A_LAST + 7'h01), 1'b0});

  // Sequencer next state; recognition ignores every mask and operating mode.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MIS_IDLE: begin
        if ((irq_low || soft_req || pend_ff) && !rsp_ff.exec_stall) begin
          nxt_state = MIS_WAIT_DONE;
        end
      end
      MIS_WAIT_DONE: begin
        if (core_req.op_done) begin
          nxt_state = MIS_SAVE_REQ;
        end
      end
      MIS_SAVE_REQ: begin
        if (!hold_gap) begin
          nxt_state = MIS_SAVE_WAIT;
        end
      end
      MIS_SAVE_WAIT: begin
        if (space_rdy) begin
          nxt_state = (xfer_idx_ff == MIS_XFER_LAST) ? MIS_HANDLER : MIS_SAVE_REQ;
        end
      end
      MIS_HANDLER: begin
        if (core_req.restore_op && !hold_gap) begin
          nxt_state = MIS_REST_REQ;
        end
      end
      MIS_REST_REQ: begin
        if (!hold_gap) begin
          nxt_state = MIS_REST_WAIT;
        end
      end
      MIS_REST_WAIT: begin
        if (space_rdy) begin
          nxt_state = (xfer_idx_ff == MIS_XFER_LAST) ? MIS_RELEASE : MIS_REST_REQ;
        end
      end
      MIS_RELEASE: begin
        if (high_cnt_ff == MIS_RELEASE_HIGH - 2'h1) begin
          nxt_state = MIS_IDLE;
        end
      end
      default: begin
        nxt_state = MIS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= MIS_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Transfer index and restore base capture.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_idx_ff  <= 7'h00;
      rest_base_ff <= 24'h00_0000;
    end else if (clk_en) begin
      if (state_ff == MIS_HANDLER && nxt_state == MIS_REST_REQ) begin
        rest_base_ff <= 24'({core_req.seg_base, 4'h0}) + core_req.offset_reg[23:0];
      end
      if ((state_ff == MIS_SAVE_WAIT || state_ff == MIS_REST_WAIT) && space_rdy) begin
        xfer_idx_ff <= (xfer_idx_ff == MIS_XFER_LAST) ? 7'h00 : xfer_idx_ff + 7'h01;
      end
    end
  end

  // Request pin drive: low for the whole routine, high twice at the end, then released.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_oe_ff   <= 1'b0;
      irq_out_ff  <= 1'b1;
      high_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      if (state_ff == MIS_IDLE && soft_req) begin
        irq_oe_ff  <= 1'b1;
        irq_out_ff <= 1'b0;
      end else if (state_ff == MIS_WAIT_DONE && core_req.op_done) begin
        irq_oe_ff  <= 1'b1;
        irq_out_ff <= 1'b0;
      end else if (state_ff == MIS_REST_WAIT && nxt_state == MIS_RELEASE) begin
        irq_out_ff  <= 1'b1;
        high_cnt_ff <= 2'h0;
      end else if (state_ff == MIS_RELEASE) begin
        high_cnt_ff <= high_cnt_ff + 2'h1;
        if (nxt_state == MIS_IDLE) begin
          irq_oe_ff <= 1'b0;
        end
      end
    end
  end

  // Management-space strobe, address and data; the strobe floats while hold is granted.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_n_ff  <= 1'b1;
      strobe_oe_ff <= 1'b0;
      addr_ff      <= 24'h00_0000;
      wdata_ff     <= 16'h0000;
      write_ff     <= 1'b0;
    end else if (clk_en) begin
      strobe_n_ff  <= 1'b1;
      strobe_oe_ff <= in_mgmt && !hold_gap;
      if (nxt_state == MIS_SAVE_WAIT && state_ff == MIS_SAVE_REQ) begin
        strobe_n_ff <= 1'b0;
        addr_ff     <= MIS_RANGE_A_BASE + rel_addr;
        wdata_ff    <= core_req.save_word;
        write_ff    <= 1'b1;
      end else if (nxt_state == MIS_REST_WAIT && state_ff == MIS_REST_REQ) begin
        strobe_n_ff <= 1'b0;
        addr_ff     <= rest_base_ff + rel_addr;
        write_ff    <= 1'b0;
      end
    end
  end

  // Bus hold is granted between management transfers while in management mode.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_ack_ff <= 1'b0;
    end else if (clk_en) begin
      if (!hold_in || !in_mgmt || nxt_state == MIS_IDLE) begin
        hold_ack_ff <= 1'b0;
      end else if (state_ff != MIS_SAVE_WAIT && state_ff != MIS_REST_WAIT) begin
        hold_ack_ff <= 1'b1;
      end
    end
  end

  // Next stall level; memory and coprocessor cycles bypass, and a new break beats a release.
  always_comb begin
    nxt_stall = rsp_ff.exec_stall;
    if (core_req.io_done && core_req.io_is_port && brk_en && !in_mgmt) begin
      nxt_stall = 1'b1;
    end else if (rsp_ff.exec_stall && io_rdy) begin
      nxt_stall = 1'b0;
    end
  end

  // Request seen during a break stall, kept until recognition takes it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (rsp_ff.exec_stall && irq_low) begin
        pend_ff <= 1'b1;
      end else if (state_ff == MIS_WAIT_DONE) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // Core indications: mode, interrupt disable, handler entry, resume and routing.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_ff.mgmt_mode        <= 1'b0;
      rsp_ff.irq_disable      <= 1'b0;
      rsp_ff.enter_handler    <= 1'b0;
      rsp_ff.handler_fetch    <= 24'h00_0000;
      rsp_ff.resume           <= 1'b0;
      rsp_ff.discard_prefetch <= 1'b0;
      rsp_ff.exec_stall       <= 1'b0;
      rsp_ff.use_mgmt_space   <= 1'b0;
      rsp_ff.restore_valid    <= 1'b0;
      rsp_ff.restore_word     <= 16'h0000;
    end else if (clk_en) begin
      rsp_ff.mgmt_mode        <= (nxt_state != MIS_IDLE) && (nxt_state != MIS_WAIT_DONE);
      rsp_ff.irq_disable      <= (nxt_state != MIS_IDLE) && (nxt_state != MIS_WAIT_DONE);
      rsp_ff.enter_handler    <= (state_ff == MIS_SAVE_WAIT) && (nxt_state == MIS_HANDLER);
      rsp_ff.handler_fetch    <= MIS_HANDLER_FETCH;
      rsp_ff.resume           <= (state_ff == MIS_RELEASE) && (nxt_state == MIS_IDLE);
      rsp_ff.discard_prefetch <= (state_ff == MIS_WAIT_DONE) && core_req.op_done;
      rsp_ff.exec_stall       <= nxt_stall;
      rsp_ff.use_mgmt_space   <= (state_ff == MIS_HANDLER) && !core_req.cycle_is_io
                                 && !core_req.cycle_is_xmove;
      rsp_ff.restore_valid    <= (state_ff == MIS_REST_WAIT) && space_rdy;
      if (state_ff == MIS_REST_WAIT && space_rdy) begin
        rsp_ff.restore_word <= mgmt_space_rdata;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign mgmt_irq_n_out           = irq_out_ff;
  assign mgmt_irq_n_oe            = irq_oe_ff;
  assign mgmt_space_addr_strobe_n = strobe_n_ff;
  assign mgmt_space_strobe_oe     = strobe_oe_ff;
  assign mgmt_space_addr          = addr_ff;
  assign mgmt_space_wdata         = wdata_ff;
  assign mgmt_space_write         = write_ff;
  assign hold_ack                 = hold_ack_ff;
  assign core_rsp                 = rsp_ff;

  // Checks kept beside the logic they guard.
  drive_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && state_ff == MIS_WAIT_DONE && core_req.op_done |=> irq_oe_ff && !irq_out_ff)
    else $error("request pin not driven low after operation completed");

  release_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_ff == MIS_RELEASE) && clk_en |-> irq_oe_ff && irq_out_ff
    ##1 (!clk_en or (irq_oe_ff && irq_out_ff)))
    else $error("request pin not held high before release");

  mgmt_disable_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_mgmt |-> rsp_ff.irq_disable && rsp_ff.mgmt_mode)
    else $error("interrupts not disabled in management mode");

  hold_float_a: assert property (@(posedge clk) disable iff (!rst_b)
    hold_ack_ff |-> !strobe_oe_ff ##0 irq_oe_ff)
    else $error("strobe driven or request released during hold");

  save_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    xfer_idx_ff <= MIS_XFER_LAST)
    else $error("transfer index beyond last save word");

  handler_fetch_a: assert property (@(posedge clk) disable iff (!rst_b)
    rsp_ff.enter_handler |-> rsp_ff.handler_fetch == MIS_HANDLER_FETCH && state_ff == MIS_HANDLER)
    else $error("handler entry without fixed fetch address");

  save_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(strobe_n_ff) && write_ff |-> (addr_ff >= MIS_RANGE_A_BASE && addr_ff <= MIS_RANGE_A_END)
    || (addr_ff >= MIS_RANGE_B_BASE && addr_ff <= MIS_RANGE_B_END))
    else $error("save address outside the save ranges");

  break_stall_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_req.io_done && core_req.io_is_port && brk_en && !in_mgmt
    |=> rsp_ff.exec_stall)
    else $error("port I/O not stalled with break enabled");

  break_skip_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_req.io_done && !core_req.io_is_port && !rsp_ff.exec_stall
    |=> !rsp_ff.exec_stall)
    else $error("break stalled a non-port cycle");

  io_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && core_req.cycle_is_io |=> !rsp_ff.use_mgmt_space || !clk_en)
    else $error("port I/O routed to management space");

  restore_resume_a: assert property (@(posedge clk) disable iff (!rst_b)
    rsp_ff.resume |-> !irq_oe_ff && state_ff == MIS_IDLE)
    else $error("resume without releasing the request pin");

  soft_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && state_ff == MIS_IDLE && soft_req |=> irq_oe_ff && !irq_out_ff)
    else $error("soft trap did not drive the request pin low");

  break_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && rsp_ff.exec_stall && io_rdy && !core_req.io_done |=> !rsp_ff.exec_stall)
    else $error("break stall not released after ready");

endmodule

// ### bench/mis_chipset_model.sv
// Chipset partner: raises the request and serves the management memory space.
`timescale 1ns/10ps
module mis_chipset_model (
  input  wire logic        clk,
  input  wire logic        want_req,
  input  wire logic [3:0]  ready_delay,
  input  wire logic        strobe_n,
  input  wire logic        strobe_oe,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        write,
  output logic             req_oe,
  output logic             ready_n,
  output logic [15:0]      rdata
);
  logic [15:0] mem [logic [23:0]];
  logic [23:0] cur;
  logic        done;
  int          wait_cnt;
  int          hold_cnt;

  // Quiet values before the first edge.
  initial begin
    req_oe = 1'b0;
    done = 1'b0;
    ready_n = 1'b1;
    rdata = 16'h0000;
    wait_cnt = 0;
    hold_cnt = 0;
  end

  // Hold the request low until the first management strobe, then let the pull-up win.
  always @(posedge clk) begin
    if (!strobe_n && strobe_oe)
      done <= want_req;
    else if (!want_req)
      done <= 1'b0;
    req_oe <= want_req && !done && !(!strobe_n && strobe_oe);
  end

  // Answer each strobe after a chosen delay, one at a time; stale read data three cycles later.
  always @(posedge clk) begin
    if (!strobe_n && strobe_oe) begin
      cur <= addr;
      wait_cnt <= ready_delay + 1;
      if (write)
        mem[addr] = wdata;
    end else if (wait_cnt == 1) begin
      ready_n <= 1'b0;
      rdata <= mem.exists(cur) ? mem[cur] : 16'h0000;
      wait_cnt <= 0;
      hold_cnt <= 3;
    end else begin
      ready_n <= 1'b1;
      if (wait_cnt > 1)
        wait_cnt <= wait_cnt - 1;
      if (hold_cnt == 1)
        rdata <= ~rdata;
      if (hold_cnt > 0)
        hold_cnt <= hold_cnt - 1;
    end
  end
endmodule

// ### bench/testbench.sv
// Self-checking bench for the management interrupt sequencer.
`timescale 1ns/10ps
module testbench
  import mis_pkg::*;
;
  logic          clk, rst_b, hold_req, io_brk_n, rdy_n, want_req, m_oe, m_rdy_n, ce;
  logic          irq_out, irq_oe, stb_n, stb_oe, wr, hack, irq_pin;
  logic [3:0]    rdly;
  logic [23:0]   addr;
  logic [15:0]   wdat, rdat;
  logic [40:0]   e;
  logic [15:0]   sv [114];
  logic [40:0]   xq [$];
  logic [15:0]   rq [$];
  mis_core_req_s creq;
  mis_core_rsp_s crsp;
  int            errors, compares, sidx, hi_cnt, i;

  // Request pin: either party may pull it low, a pull-up holds it high otherwise.
  assign irq_pin = irq_oe ? irq_out : !m_oe;

  mis_sequencer dut (.clk(clk), .rst_b(rst_b), .clk_en(ce), .mgmt_irq_n_in(irq_pin),
    .mgmt_irq_n_out(irq_out), .mgmt_irq_n_oe(irq_oe), .mgmt_space_addr_strobe_n(stb_n),
    .mgmt_space_strobe_oe(stb_oe), .mgmt_space_addr(addr), .mgmt_space_wdata(wdat),
    .mgmt_space_write(wr), .mgmt_space_rdata(rdat), .mgmt_space_ready_n(m_rdy_n),
    .hold_req(hold_req), .hold_ack(hack), .io_break_enable_n(io_brk_n), .ready_n(rdy_n),
    .core_req(creq), .core_rsp(crsp));
  mis_chipset_model partner (.clk(clk), .want_req(want_req), .ready_delay(rdly),
    .strobe_n(stb_n), .strobe_oe(stb_oe), .addr(addr), .wdata(wdat), .write(wr),
    .req_oe(m_oe), .ready_n(m_rdy_n), .rdata(rdat));

  // Clock of 100 ns period.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  function automatic logic [23:0] addr_of(input int k);
    if (k < MIS_RANGE_A_WORDS)
      return MIS_RANGE_A_BASE + 24'(2 * k);
    return MIS_RANGE_B_BASE + 24'(2 * (k - MIS_RANGE_A_WORDS));
  endfunction

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic io_pulse(input logic port);
    @(posedge clk);
    creq.io_done <= 1'b1;
    creq.io_is_port <= port;
    creq.cycle_is_io <= 1'b1;
    @(posedge clk);
    creq.io_done <= 1'b0;
  endtask

  // Each strobe and each restored word is matched against the oldest note.
  always @(posedge clk) begin
    if (irq_oe && irq_out)
      hi_cnt++;
    if (rst_b && !stb_n && stb_oe) begin
      e = xq.pop_front();
      check("addr", e[40:17], addr);
      check("write", e[16], wr);
      if (wr) begin
        check("wdata", e[15:0], wdat);
        sidx++;
      end
      creq.save_word <= sv[sidx % 114];
    end
    if (rst_b && crsp.restore_valid)
      check("rword", rq.pop_front(), crsp.restore_word);
  end

  // One whole routine: 0 pin request, 1 soft trap, 2 trapped port I/O.
  task automatic run_routine(input int mode);
    sidx = 0;
    hi_cnt = 0;
    rdly <= 4'($urandom_range(0, 6));
    for (int k = 0; k < 114; k++) begin
      sv[k] = 16'($urandom);
      xq.push_back({addr_of(k), 1'b1, sv[k]});
    end
    for (int k = 0; k < 114; k++) begin
      xq.push_back({addr_of(k), 1'b0, 16'h0000});
      rq.push_back(sv[k]);
    end
    creq.save_word <= sv[0];
    if (mode == 2) begin
      io_pulse(1'b1);
      repeat (3) @(negedge clk);
      check("stall", 1, crsp.exec_stall);
    end
    @(posedge clk);
    if (mode == 1) begin
      creq.debug_control_reg[MIS_DBG_SOFT_BIT] <= 1'b1;
      creq.soft_trap <= 1'b1;
      @(posedge clk);
      creq.soft_trap <= 1'b0;
    end else begin
      want_req <= 1'b1;
      if (mode == 2) begin
        repeat (4) @(posedge clk);
        rdy_n <= 1'b0;
        @(posedge clk);
        rdy_n <= 1'b1;
        for (i = 0; i < 8 && crsp.exec_stall !== 1'b0; i++) @(negedge clk);
        check("unstall", 0, crsp.exec_stall);
      end
      repeat (5) @(negedge clk);
      check("early", 0, irq_oe);
    end
    @(posedge clk);
    creq.op_done <= 1'b1;
    @(posedge clk);
    creq.op_done <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 8 && irq_oe !== 1'b1; i++) @(negedge clk);
    check("drive", 0, irq_pin);
    check("discard", 1, crsp.discard_prefetch);
    for (i = 0; i < 2000 && sidx < 50; i++) @(negedge clk);
    check("mode", 1, crsp.mgmt_mode);
    check("irq_off", 1, crsp.irq_disable);
    @(posedge clk);
    hold_req <= 1'b1;
    for (i = 0; i < 40 && hack !== 1'b1; i++) @(negedge clk);
    check("hold_ack", 1, hack);
    check("stb_float", 0, stb_oe);
    check("pin_held", 0, irq_pin);
    repeat (6) @(posedge clk);
    hold_req <= 1'b0;
    want_req <= 1'b0;
    for (i = 0; i < 3000 && crsp.enter_handler !== 1'b1; i++) @(negedge clk);
    check("fetch", MIS_HANDLER_FETCH, crsp.handler_fetch);
    check("saves", 114, sidx);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      creq.cycle_is_io <= (c == 1);
      creq.cycle_is_xmove <= (c == 2);
      repeat (3) @(negedge clk);
      check("route", c == 0, crsp.use_mgmt_space);
    end
    // With the clock enable low the routing flag must not follow the cycle kind.
    @(posedge clk);
    ce <= 1'b0;
    creq.cycle_is_xmove <= 1'b0;
    repeat (3) @(negedge clk);
    check("freeze", 0, crsp.use_mgmt_space);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    creq.cycle_is_xmove <= 1'b0;
    creq.seg_base <= 16'h5000;
    creq.offset_reg <= 32'h0001_0000;
    creq.restore_op <= 1'b1;
    @(posedge clk);
    creq.restore_op <= 1'b0;
    for (i = 0; i < 3000 && crsp.resume !== 1'b1; i++) @(negedge clk);
    check("high_len", 2, hi_cnt);
    check("release", 0, irq_oe);
    check("left", 0, xq.size() + rq.size());
    $display("routine %0d done", mode);
  endtask

  // Watchdog well beyond three routines.
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end

  // Main sequence.
  initial begin
    void'($urandom(44291));
    rst_b = 1'b0;
    ce = 1'b1;
    hold_req = 1'b0;
    io_brk_n = 1'b1;
    rdy_n = 1'b1;
    want_req = 1'b0;
    rdly = 4'h2;
    creq = '0;
    errors = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("oe_rst", 0, irq_oe);
    check("stb_rst", 1, stb_n);
    check("hold_rst", 0, hack);
    $display("reset test done");
    creq.soft_trap <= 1'b1;
    @(posedge clk);
    creq.soft_trap <= 1'b0;
    io_pulse(1'b1);
    repeat (5) @(negedge clk);
    check("soft_off", 0, irq_oe);
    check("no_brk", 0, crsp.exec_stall);
    @(posedge clk);
    io_brk_n <= 1'b0;
    repeat (3) @(posedge clk);
    io_pulse(1'b0);
    repeat (4) @(negedge clk);
    check("stall_mem", 0, crsp.exec_stall);
    $display("quiet cases test done");
    run_routine(0);
    run_routine(1);
    run_routine(2);
    wrap_up();
  end
endmodule
